// ### rtl/bb_pin_mux.sv
// Baseband codec port pin mux with AXI4-Lite registers and receive bit FIFO.
//
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps

// Small synchronous FIFO; depth must be a power of two.
module bb_stream_fifo
  import bb_pin_mux_pkg::*;
#(
  parameter int WIDTH = `BB_FIFO_WIDTH,
  parameter int DEPTH = `BB_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  // Filling side
  input  wire logic                     in_valid,
  output logic                          in_ready,
  input  wire logic [WIDTH-1:0]         in_data,
  // Draining side
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [WIDTH-1:0]              out_data,
  // Fill level
  output logic [$clog2(DEPTH):0]        level
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wptr;
    logic [AW:0]                 rptr;
  } fifo_state_t;

  fifo_state_t st;
  fifo_state_t next_st;
  logic        push;
  logic        pop;

  // Full and empty come from the extra wrap bit of each pointer.
  assign level     = st.wptr - st.rptr;
  assign in_ready  = (level != DEPTH[AW:0]);
  assign out_valid = (st.wptr != st.rptr);
  assign out_data  = st.mem[st.rptr[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointer and storage update.
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wptr[AW-1:0]] = in_data;
      next_st.wptr = st.wptr + 1'b1;
    end
    if (pop) begin
      next_st.rptr = st.rptr + 1'b1;
    end
  end

  // Register the state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

// Summary of operation
// [RULE1] After reset every port pin is undriven until software gives it a function.
// [RULE2] A pin's pull resistor is disconnected whenever that pin is driven as an output.
// [RULE3] The transmit-data pin carries the unit's transmit bits, or is GPIO when unused.
// [RULE4] The receive-data pin is sampled into the receive path, or is GPIO when unused.
// [RULE5] The serial clock clocks transmit and receive in sync mode, only transmit in async.
// [RULE6] When the clock function is off the serial clock pin is GPIO.
// [RULE7] With route enable set the unit's clock terminal goes through the adapter logic.
// [RULE8] With route enable set a GPIO read of the clock pin returns the adapter output.
// [RULE9] The pin enable bit decides whether the clock pin is tied to the unit or left free.
// [RULE10] Control pin 0 is a serial flag in sync mode and the receive clock in async mode.
// [RULE11] Control pin 1 is a serial flag in sync mode and receive frame sync in async mode.
// [RULE12] Control pin 2 is the shared frame sync in sync mode, transmit frame sync in async.
// [RULE13] The alternate receive-data pin is an input feeding the receive path when in use.
// [RULE14] The pin enable bit decides whether the alternate receive pin is tied to the unit.
// [RULE15] The alternate receive pin resets to GPIO input and is GPIO whenever unused.
// [RULE16] The alternate clock pin mirrors the primary clock pin under the same two bits.
// [RULE17] Every pin has software direction, output value and readable input as GPIO.
module bb_pin_mux
  import bb_pin_mux_pkg::*;
(
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite write address
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [`BB_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  // AXI4-Lite write data
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  // AXI4-Lite write response
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  output logic [1:0]                 s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  input  wire logic [`BB_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  // AXI4-Lite read data
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  // Port pins, index order tx, rx, sck, ctrl0, ctrl1, ctrl2, rx alt, sck alt
  input  wire logic [`BB_NPINS-1:0]  pin_in,
  output logic [`BB_NPINS-1:0]       pin_out,
  output logic [`BB_NPINS-1:0]       pin_oe,
  output logic [`BB_NPINS-1:0]       pull_connect,
  // Serial unit side
  input  wire unit_drive_t           unit_drive,
  output unit_roles_t                unit_roles,
  output logic                       rx_valid,
  input  wire logic                  rx_ready,
  output rx_word_t                   rx_word,
  // Codec adapter logic
  input  wire logic                  adapter_clk,
  output logic                       adapter_pin_level
);

  mux_state_t              st;
  mux_state_t              next_st;
  logic                    route;
  logic                    pin_en;
  logic                    sync_mode;
  logic [`BB_NPINS-1:0]    own;
  logic [`BB_NPINS-1:0]    fun_out;
  logic [`BB_NPINS-1:0]    fun_oe;
  logic [`BB_NPINS-1:0]    gpio_in;
  logic                    sck_pin_level;
  logic                    sck_level;
  logic                    rx_bit_level;
  logic                    rxclk_level;
  logic                    rx_edge;
  logic                    push_ready;
  logic [`BB_LVL_W-1:0]    fifo_level;
  logic                    wr_fire;
  logic                    rd_fire;
  logic [31:0]             wmask;
  logic [31:0]             wmerge_ctrl;
  logic [31:0]             wmerge_dir;
  logic [31:0]             wmerge_gout;
  logic [31:0]             wmerge_pull;
  rx_word_t                push_word;

  // Control bits in short form.
  assign route     = st.ctrl[`BB_CTRL_ROUTE];
  assign pin_en    = st.ctrl[`BB_CTRL_PINEN];
  assign sync_mode = st.ctrl[`BB_CTRL_SYNC];

  // Pin ownership; the pin enable bit picks primary or alternate clock and receive pins.
  always_comb begin
    own = '0;
    own[`BB_PIN_TX]      = st.ctrl[`BB_CTRL_TX_EN]; // [RULE3]
    own[`BB_PIN_RX]      = st.ctrl[`BB_CTRL_RX_EN] && !pin_en; // [RULE4]
    own[`BB_PIN_SCK]     = st.ctrl[`BB_CTRL_SCK_EN] && !pin_en; // [RULE6] [RULE9]
    own[`BB_PIN_C0]      = st.ctrl[`BB_CTRL_C0_EN];
    own[`BB_PIN_C1]      = st.ctrl[`BB_CTRL_C1_EN]; // [RULE11]
    own[`BB_PIN_C2]      = st.ctrl[`BB_CTRL_C2_EN];
    own[`BB_PIN_RX_ALT]  = st.ctrl[`BB_CTRL_RX_EN] && pin_en; // [RULE14]
    own[`BB_PIN_SCK_ALT] = st.ctrl[`BB_CTRL_SCK_EN] && pin_en; // [RULE16]
  end

  // Function drive per pin; receive pins never drive while they serve the unit.
  always_comb begin
    fun_out = '0;
    fun_oe  = '0;
    fun_out[`BB_PIN_TX]      = unit_drive.tx_bit; // [RULE3]
    fun_oe[`BB_PIN_TX]       = 1'b1;
    fun_out[`BB_PIN_SCK]     = route ? adapter_clk : unit_drive.sck_out; // [RULE7]
    fun_oe[`BB_PIN_SCK]      = unit_drive.sck_oe; // [RULE5]
    fun_out[`BB_PIN_SCK_ALT] = route ? adapter_clk : unit_drive.sck_out; // [RULE16]
    fun_oe[`BB_PIN_SCK_ALT]  = unit_drive.sck_oe;
    fun_out[`BB_PIN_C0]      = unit_drive.ctrl_out[0]; // [RULE10]
    fun_oe[`BB_PIN_C0]       = unit_drive.ctrl_oe[0];
    fun_out[`BB_PIN_C1]      = unit_drive.ctrl_out[1]; // [RULE11]
    fun_oe[`BB_PIN_C1]       = unit_drive.ctrl_oe[1];
    fun_out[`BB_PIN_C2]      = unit_drive.ctrl_out[2]; // [RULE12]
    fun_oe[`BB_PIN_C2]       = unit_drive.ctrl_oe[2];
    fun_oe[`BB_PIN_RX]       = 1'b0; // [RULE13]
    fun_oe[`BB_PIN_RX_ALT]   = 1'b0;
  end

  // Clock and receive levels seen by the unit, taken from the synchronised pins except the clock, which is adapter_clk while routing is on.
  assign sck_pin_level = pin_en ? st.sync2[`BB_PIN_SCK_ALT] : st.sync2[`BB_PIN_SCK];
  assign sck_level     = route ? adapter_clk : sck_pin_level; // [RULE7]
  assign rx_bit_level  = pin_en ? st.sync2[`BB_PIN_RX_ALT] : st.sync2[`BB_PIN_RX]; // [RULE14]
  assign rxclk_level   = sync_mode ? sck_level : st.sync2[`BB_PIN_C0]; // [RULE5]
  assign rx_edge       = st.ctrl[`BB_CTRL_RX_EN] && rxclk_level && !st.rxclk_prev; // [RULE4]

  // GPIO read value; with routing on, the clock bits show the adapter output instead.
  always_comb begin
    gpio_in = st.sync2;
    if (route) begin
      gpio_in[`BB_PIN_SCK]     = adapter_clk; // [RULE8]
      gpio_in[`BB_PIN_SCK_ALT] = adapter_clk; // [RULE16]
    end
  end

  // Byte-lane mask and merged write values for the writable registers.
  assign wmask       = {{8{st.wstrb[3]}}, {8{st.wstrb[2]}}, {8{st.wstrb[1]}}, {8{st.wstrb[0]}}};
  assign wmerge_ctrl = ({20'h00000, st.ctrl} & ~wmask) | (st.wdata & wmask);
  assign wmerge_dir  = ({24'h000000, st.dir} & ~wmask) | (st.wdata & wmask);
  assign wmerge_gout = ({24'h000000, st.gout} & ~wmask) | (st.wdata & wmask);
  assign wmerge_pull = ({24'h000000, st.pull} & ~wmask) | (st.wdata & wmask);
  assign wr_fire     = st.aw_got && st.w_got && !st.bvalid;
  assign rd_fire     = s_axi_arvalid && !st.rvalid;

  // Received bits carry the frame sync level of their own direction.
  assign push_word.bit_val = rx_bit_level;
  assign push_word.fs      = sync_mode ? st.sync2[`BB_PIN_C2] : st.sync2[`BB_PIN_C1]; // [RULE12]

  // Next-state logic: synchronisers, pin drivers, roles and the register slave.
  always_comb begin
    next_st            = st;
    next_st.sync1      = pin_in;
    next_st.sync2      = st.sync1;
    next_st.rxclk_prev = rxclk_level;

    // GPIO owns a pin whenever the function does not; reset values leave all undriven.
    for (int i = 0; i < `BB_NPINS; i++) begin
      next_st.pin_out[i] = own[i] ? fun_out[i] : st.gout[i]; // [RULE17]
      next_st.pin_oe[i]  = own[i] ? fun_oe[i] : st.dir[i]; // [RULE1]
    end

    // Role decode follows the clock mode.
    next_st.roles.tx_clk = sck_level; // [RULE5]
    if (sync_mode) begin
      next_st.roles.rx_clk = sck_level; // [RULE5]
      next_st.roles.tx_fs  = st.sync2[`BB_PIN_C2]; // [RULE12]
      next_st.roles.rx_fs  = st.sync2[`BB_PIN_C2];
      next_st.roles.flag0  = st.sync2[`BB_PIN_C0]; // [RULE10]
      next_st.roles.flag1  = st.sync2[`BB_PIN_C1]; // [RULE11]
    end else begin
      next_st.roles.rx_clk = st.sync2[`BB_PIN_C0]; // [RULE10]
      next_st.roles.tx_fs  = st.sync2[`BB_PIN_C2]; // [RULE12]
      next_st.roles.rx_fs  = st.sync2[`BB_PIN_C1]; // [RULE11]
      next_st.roles.flag0  = 1'b0;
      next_st.roles.flag1  = 1'b0;
    end

    // Address and data are caught independently, in either order.
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.w_got = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end

    // Overflow is sticky; an edge lost to a full FIFO wins over a clear in the same cycle.
    if (wr_fire) begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = `BB_RESP_OKAY;
      if (st.awaddr == `BB_OFF_CTRL) begin
        next_st.ctrl = wmerge_ctrl[`BB_CTRL_W-1:0];
      end else if (st.awaddr == `BB_OFF_DIR) begin
        next_st.dir = wmerge_dir[`BB_NPINS-1:0]; // [RULE17]
      end else if (st.awaddr == `BB_OFF_GOUT) begin
        next_st.gout = wmerge_gout[`BB_NPINS-1:0];
      end else if (st.awaddr == `BB_OFF_PULL) begin
        next_st.pull = wmerge_pull[`BB_NPINS-1:0];
      end else if (st.awaddr == `BB_OFF_STATUS) begin
        if (st.wstrb[0] && st.wdata[`BB_STAT_OVF]) begin
          next_st.overflow = 1'b0;
        end
      end else if (st.awaddr != `BB_OFF_GIN) begin
        next_st.bresp = `BB_RESP_SLVERR;
      end
    end
    if (rx_edge && !push_ready) begin
      next_st.overflow = 1'b1;
    end

    // Reads answer one cycle after the address is taken; unmapped reads give zero.
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (rd_fire) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = `BB_RESP_OKAY;
      next_st.rdata  = 32'h00000000;
      if (s_axi_araddr == `BB_OFF_CTRL) begin
        next_st.rdata[`BB_CTRL_W-1:0] = st.ctrl;
      end else if (s_axi_araddr == `BB_OFF_DIR) begin
        next_st.rdata[`BB_NPINS-1:0] = st.dir;
      end else if (s_axi_araddr == `BB_OFF_GOUT) begin
        next_st.rdata[`BB_NPINS-1:0] = st.gout;
      end else if (s_axi_araddr == `BB_OFF_GIN) begin
        next_st.rdata[`BB_NPINS-1:0] = gpio_in; // [RULE17]
      end else if (s_axi_araddr == `BB_OFF_PULL) begin
        next_st.rdata[`BB_NPINS-1:0] = st.pull;
      end else if (s_axi_araddr == `BB_OFF_STATUS) begin
        next_st.rdata[`BB_STAT_OVF] = st.overflow;
        next_st.rdata[`BB_STAT_LVL_LSB +: `BB_LVL_W] = fifo_level;
      end else begin
        next_st.rresp = `BB_RESP_SLVERR;
      end
    end
  end

  // Register the whole state; reset puts every pin in input, alternate rx as GPI.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st      <= '0;
      st.ctrl <= `BB_RST_CTRL;
      st.dir  <= `BB_RST_DIR; // [RULE15]
      st.gout <= `BB_RST_GOUT;
      st.pull <= `BB_RST_PULL;
    end else begin
      st <= next_st;
    end
  end

  // The FIFO absorbs bursts of receive edges while the unit stalls.
  bb_stream_fifo #(
    .WIDTH (`BB_FIFO_WIDTH),
    .DEPTH (`BB_FIFO_DEPTH)
  ) u_rx_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (rx_edge),
    .in_ready  (push_ready),
    .in_data   (push_word),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_word),
    .level     (fifo_level)
  );

  // Outputs; pulls stay connected only while a pin is not driven.
  assign pin_out           = st.pin_out;
  assign pin_oe            = st.pin_oe;
  assign pull_connect      = st.pull & ~st.pin_oe; // [RULE2]
  assign unit_roles        = st.roles;
  assign adapter_pin_level = sck_pin_level;
  assign s_axi_awready     = !st.aw_got && !st.bvalid;
  assign s_axi_wready      = !st.w_got && !st.bvalid;
  assign s_axi_bvalid      = st.bvalid;
  assign s_axi_bresp       = st.bresp;
  assign s_axi_arready     = !st.rvalid;
  assign s_axi_rvalid      = st.rvalid;
  assign s_axi_rdata       = st.rdata;
  assign s_axi_rresp       = st.rresp;

endmodule

// ### rtl/bb_pin_mux_regs.svh
// Register offsets, field positions and reset values of the baseband pin mux.
`ifndef BB_PIN_MUX_REGS_SVH
`define BB_PIN_MUX_REGS_SVH

`define BB_ADDR_W        8
`define BB_NPINS         8
`define BB_CTRL_W        12
`define BB_LVL_W         4
`define BB_FIFO_DEPTH    8
`define BB_FIFO_WIDTH    2

`define BB_OFF_CTRL      8'h00
`define BB_OFF_DIR       8'h04
`define BB_OFF_GOUT      8'h08
`define BB_OFF_GIN       8'h0c
`define BB_OFF_PULL      8'h10
`define BB_OFF_STATUS    8'h14

`define BB_CTRL_ROUTE    0
`define BB_CTRL_PINEN    1
`define BB_CTRL_SYNC     2
`define BB_CTRL_TX_EN    4
`define BB_CTRL_RX_EN    5
`define BB_CTRL_SCK_EN   6
`define BB_CTRL_C0_EN    7
`define BB_CTRL_C1_EN    8
`define BB_CTRL_C2_EN    9

`define BB_PIN_TX        0
`define BB_PIN_RX        1
`define BB_PIN_SCK       2
`define BB_PIN_C0        3
`define BB_PIN_C1        4
`define BB_PIN_C2        5
`define BB_PIN_RX_ALT    6
`define BB_PIN_SCK_ALT   7

`define BB_STAT_OVF      0
`define BB_STAT_LVL_LSB  4

`define BB_RST_CTRL      12'h000
`define BB_RST_DIR       8'h00
`define BB_RST_GOUT      8'h00
`define BB_RST_PULL      8'hff

`define BB_RESP_OKAY     2'b00
`define BB_RESP_SLVERR   2'b10

`endif

// ### rtl/bb_pin_mux_pkg.sv
// Types shared by the baseband pin mux and its receive FIFO.
package bb_pin_mux_pkg;
  `include "bb_pin_mux_regs.svh"

  // Drive requests from the serial unit toward the pins.
  typedef struct packed {
    logic       tx_bit;
    logic       sck_out;
    logic       sck_oe;
    logic [2:0] ctrl_out;
    logic [2:0] ctrl_oe;
  } unit_drive_t;

  // Decoded pin roles handed to the serial unit.
  typedef struct packed {
    logic tx_clk;
    logic rx_clk;
    logic tx_fs;
    logic rx_fs;
    logic flag0;
    logic flag1;
  } unit_roles_t;

  // One received bit with the frame sync level seen at its sampling edge.
  typedef struct packed {
    logic fs;
    logic bit_val;
  } rx_word_t;

  typedef struct packed {
    logic [`BB_NPINS-1:0]  sync1;
    logic [`BB_NPINS-1:0]  sync2;
    logic                  rxclk_prev;
    logic [`BB_CTRL_W-1:0] ctrl;
    logic [`BB_NPINS-1:0]  dir;
    logic [`BB_NPINS-1:0]  gout;
    logic [`BB_NPINS-1:0]  pull;
    logic                  overflow;
    logic [`BB_NPINS-1:0]  pin_out;
    logic [`BB_NPINS-1:0]  pin_oe;
    unit_roles_t           roles;
    logic                  aw_got;
    logic                  w_got;
    logic [`BB_ADDR_W-1:0] awaddr;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
  } mux_state_t;
endpackage

// ### sim/bb_pin_mux_properties.sv
// Port-level assertions for the baseband pin mux.
`timescale 1ns/1ps
module bb_pin_mux_properties
  import bb_pin_mux_pkg::*;
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Pins and serial unit
  input wire logic [7:0]  pin_in,
  input wire logic [7:0]  pin_out,
  input wire logic [7:0]  pin_oe,
  input wire logic [7:0]  pull_connect,
  input wire unit_drive_t unit_drive,
  input wire unit_roles_t unit_roles,
  input wire logic        rx_valid,
  input wire logic        rx_ready,
  input wire rx_word_t    rx_word
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0]  awa;
  logic [11:0] wd;
  logic [11:0] ctl;
  // Mirror of the control word; it lags the real register by one edge, as pin outputs do.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awa <= 8'h00;
      wd  <= 12'h000;
      ctl <= `BB_RST_CTRL;
    end else begin
      if (s_axi_awvalid && s_axi_awready) awa <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata[11:0];
      if (s_axi_bvalid && s_axi_bready && awa == `BB_OFF_CTRL) ctl <= wd;
    end
  end
  property p_reset_idle; $rose(aresetn) |-> pin_oe == 8'h00 && pull_connect == 8'hff; endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("pins not idle after reset");
  property p_pull_off; (pin_oe & pull_connect) == 8'h00; endproperty
  a_pull_off: assert property (p_pull_off) else $error("pull left on driven pin");
  property p_tx_path;
    ctl[`BB_CTRL_TX_EN] |-> pin_oe[0] && pin_out[0] == $past(unit_drive.tx_bit);
  endproperty
  a_tx_path: assert property (p_tx_path) else $error("tx pin not following unit");
  property p_rx_undriven;
    ctl[`BB_CTRL_RX_EN] && $stable(ctl) |-> !(ctl[`BB_CTRL_PINEN] ? pin_oe[6] : pin_oe[1]);
  endproperty
  a_rx_undriven: assert property (p_rx_undriven) else $error("rx pin driven");
  property p_sync_clk;
    ctl[`BB_CTRL_SYNC] && ctl[`BB_CTRL_SCK_EN] && $stable(ctl) |->
      unit_roles.rx_clk == unit_roles.tx_clk;
  endproperty
  a_sync_clk: assert property (p_sync_clk) else $error("sync clocks differ");
  property p_async_rxclk;
    !ctl[`BB_CTRL_SYNC] && ctl[`BB_CTRL_C0_EN] && ctl == $past(ctl, 3) |->
      unit_roles.rx_clk == $past(pin_in[3], 3);
  endproperty
  a_async_rxclk: assert property (p_async_rxclk) else $error("async rx clock wrong");
  property p_b_latency;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
  endproperty
  a_b_latency: assert property (p_b_latency) else $error("write response late");
  property p_bad_addr; s_axi_bvalid && awa > `BB_OFF_STATUS |-> s_axi_bresp == 2'b10; endproperty
  a_bad_addr: assert property (p_bad_addr) else $error("unmapped write not refused");
  property p_rx_hold; rx_valid && !rx_ready |=> rx_valid && $stable(rx_word); endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx word dropped");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data not held");
endmodule

bind bb_pin_mux bb_pin_mux_properties chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .pin_in, .pin_out, .pin_oe,
  .pull_connect, .unit_drive, .unit_roles, .rx_valid, .rx_ready, .rx_word);

// ### sim/bb_codec_model.sv
// Behavioural baseband codec that drives clock, data and frame sync pins.
`timescale 1ns/1ps
module bb_codec_model (
  // Layout: 0 sync primary, 1 sync alternate, 2 async
  input  wire logic [1:0] layout,
  // Device side
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pull_connect,
  // Resolved wire levels
  output logic [7:0]      pin_level
);
  logic       ck, dt, fs;
  logic       act = 1'b0;
  logic [7:0] flip = 8'h5a;
  int         ci;
  int         di;
  int         fi;
  // Floating pins without a pull wander so that no stale level can pass as real.
  always #4 flip = ~flip;
  // Wire resolution: device drive, then codec drive in a frame, then pull, then noise.
  always_comb begin
    ci = layout == 2'd1 ? 7 : (layout == 2'd2 ? 3 : 2);
    di = layout == 2'd1 ? 6 : 1;
    fi = layout == 2'd2 ? 4 : 5;
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) pin_level[i] = pin_out[i];
      else if (act && i == ci) pin_level[i] = ck;
      else if (act && i == di) pin_level[i] = dt;
      else if (act && i == fi) pin_level[i] = fs;
      else if (pull_connect[i]) pin_level[i] = (i == 0);
      else pin_level[i] = flip[i];
    end
  end
  // One frame, first bit first, sync high on the first bit; clock stands still outside.
  task automatic send(input logic [15:0] bits, input int n);
    // Step off the bus clock edge so that no pin moves while a flop samples it.
    #1;
    act = 1'b1;
    for (int i = 0; i < n; i++) begin
      ck = 1'b0;
      dt = bits[i];
      fs = (i == 0);
      #40;
      ck = 1'b1;
      #40;
    end
    act = 1'b0;
  endtask
endmodule

// ### sim/tb.sv
// Self-checking bench for the baseband pin mux.
`timescale 1ns/1ps
module tb
  import bb_pin_mux_pkg::*;
;
  logic aclk, aresetn, aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r, rx_v, rx_r, adp;
  logic [7:0]  aw_a, ar_a, pin_in, pin_out, pin_oe, pull_c;
  logic [31:0] w_d, r_d;
  logic [1:0]  b_p, r_p, layout;
  unit_drive_t udrv;
  unit_roles_t roles;
  rx_word_t    rx_w;
  int          num_errors, check_count;
  bb_pin_mux dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
    .s_axi_awaddr(aw_a), .s_axi_awprot(3'h0), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
    .s_axi_wdata(w_d), .s_axi_wstrb(4'hf), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
    .s_axi_bresp(b_p), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r), .s_axi_araddr(ar_a),
    .s_axi_arprot(3'h0), .s_axi_rvalid(r_v), .s_axi_rready(r_r), .s_axi_rdata(r_d),
    .s_axi_rresp(r_p), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pull_connect(pull_c), .unit_drive(udrv), .unit_roles(roles), .rx_valid(rx_v),
    .rx_ready(rx_r), .rx_word(rx_w), .adapter_clk(adp), .adapter_pin_level());
  bb_codec_model codec_u (.layout(layout), .pin_out(pin_out), .pin_oe(pin_oe),
    .pull_connect(pull_c), .pin_level(pin_in));
  // Free-running bus clock.
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // A wait that ran out is a fault and ends the run.
  task automatic bound(input int t);
    if (t >= 40) begin
      num_errors++;
      final_report();
    end
  endtask
  task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int t;
    @(posedge aclk);
    aw_v <= 1'b1;
    aw_a <= a;
    w_v  <= 1'b1;
    w_d  <= d;
    b_r  <= 1'b1;
    for (t = 0; t < 40; t++) begin
      @(posedge aclk);
      if (aw_v && aw_r) aw_v <= 1'b0;
      if (w_v && w_r) w_v <= 1'b0;
      if (b_v) break;
    end
    bound(t);
    b_r <= 1'b0;
    check("bresp", {30'h0, er}, {30'h0, b_p});
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int t;
    @(posedge aclk);
    ar_v <= 1'b1;
    ar_a <= a;
    r_r  <= 1'b1;
    for (t = 0; t < 40; t++) begin
      @(posedge aclk);
      if (ar_v && ar_r) ar_v <= 1'b0;
      if (r_v) break;
    end
    bound(t);
    r_r <= 1'b0;
    check("rdata", exp, r_d);
    check("rresp", {30'h0, er}, {30'h0, r_p});
  endtask
  // Undriven pins sit at their pull level: pull-up on transmit data, pull-down elsewhere.
  function automatic logic [31:0] gpin_exp(input logic [31:0] dir, input logic [31:0] gout);
    return (dir & gout & 32'hff) | (~dir & 32'h01);
  endfunction
  // Program roles, let the codec send a frame into a stalled buffer, then drain it.
  task automatic rx_frame(input logic [1:0] l, input logic [31:0] c, input int n);
    logic [15:0] bits;
    int          t;
    bits = 16'($urandom);
    layout <= l;
    wrc(`BB_OFF_CTRL, c, `BB_RESP_OKAY);
    repeat (4) @(posedge aclk);
    codec_u.send(bits, n);
    repeat (6) @(posedge aclk);
    if (n > 8) begin
      rdc(`BB_OFF_STATUS, 32'h81, `BB_RESP_OKAY);
      wrc(`BB_OFF_STATUS, 32'h1, `BB_RESP_OKAY);
      rdc(`BB_OFF_STATUS, 32'h80, `BB_RESP_OKAY);
    end
    rx_r <= 1'b1;
    for (int i = 0; i < (n > 8 ? 8 : n); i++) begin
      t = 0;
      do begin
        @(posedge aclk);
        t++;
      end while (!rx_v && t < 40);
      bound(t);
      check("rx word", {30'h0, i == 0, bits[i]}, {30'h0, rx_w});
    end
    rx_r <= 1'b0;
    repeat (2) @(posedge aclk);
    check("rx empty", 32'h0, {31'h0, rx_v});
  endtask
  // Main sequence.
  initial begin
    logic [31:0] v, d;
    {aresetn, aw_v, w_v, b_r, ar_v, r_r, rx_r, adp} = 8'h00;
    {aw_a, ar_a, w_d, layout} = '0;
    udrv = '0;
    num_errors = 0;
    check_count = 0;
    v = $urandom(97);
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    check("oe", 32'h0, {24'h0, pin_oe});
    rdc(`BB_OFF_CTRL, 32'h0, `BB_RESP_OKAY);
    rdc(`BB_OFF_PULL, 32'hff, `BB_RESP_OKAY);
    rdc(`BB_OFF_GIN, 32'h01, `BB_RESP_OKAY);
    rdc(8'h40, 32'h0, `BB_RESP_SLVERR);
    for (int k = 0; k < 5; k++) begin
      v = k == 0 ? 32'hff : $urandom & 32'hff;
      d = $urandom & 32'hff;
      wrc(`BB_OFF_DIR, v, `BB_RESP_OKAY);
      wrc(`BB_OFF_GOUT, d, `BB_RESP_OKAY);
      repeat (4) @(posedge aclk);
      check("oe", v, {24'h0, pin_oe});
      check("pull", ~v & 32'hff, {24'h0, pull_c});
      rdc(`BB_OFF_GIN, gpin_exp(v, d), `BB_RESP_OKAY);
    end
    wrc(`BB_OFF_DIR, 32'h0, `BB_RESP_OKAY);
    wrc(`BB_OFF_GIN, 32'hff, `BB_RESP_OKAY);
    wrc(8'h30, 32'hff, `BB_RESP_SLVERR);
    rdc(`BB_OFF_GOUT, d, `BB_RESP_OKAY);
    wrc(`BB_OFF_CTRL, 32'h10, `BB_RESP_OKAY);
    repeat (16) @(posedge aclk) udrv.tx_bit <= 1'($urandom);
    check("tx oe", 32'h1, {31'h0, pin_oe[0]});
    rx_frame(2'd0, 32'h264, 8);
    rx_frame(2'd1, 32'h266, 5);
    rx_frame(2'd2, 32'h1a0, 6);
    rx_frame(2'd0, 32'h264, 10);
    wrc(`BB_OFF_CTRL, 32'h5, `BB_RESP_OKAY);
    for (int k = 0; k < 2; k++) begin
      adp <= k[0];
      repeat (3) @(posedge aclk);
      rdc(`BB_OFF_GIN, k ? 32'h85 : 32'h01, `BB_RESP_OKAY);
    end
    final_report();
  end
endmodule
